// ### hdl/sfcfs_regs.vh
// Notes on behaviour
// - flag bit 7 low busy, high ready
// - busy tracks only program and erase
// - flag bit 6 shows erase suspend
// - flag bit 2 shows program suspend
// - flag bit 5 records erase failure
// - flag bit 4 records program failure
// - flag bit 1 records protected sector hit
// - locked one-time area program sets protection
// - flags volatile, read by 70h everywhere
// - busy and suspend flags clear themselves
// - error flags held until 50h clears
// - modify command during pending error is an error
// - 9E/9F extended only, AF dual/quad
// - 5Ah accepted always, streams while clocked
// - 3Bh accepted except in quad
// - BBh two-line io; dual aliases 0B/3B
// - 6Bh accepted except in dual
// - EBh four-line io; quad aliases 0B/6B
// - register and id commands have no address
// - reads: three address bytes, dummy 8/10 except 03h/E8h
`ifndef SFCFS_REGS_VH
`define SFCFS_REGS_VH
// ***************
// flag bits
// ***************
`define SFCFS_F_READY 7
`define SFCFS_F_ESUSP 6
`define SFCFS_F_EERR 5
`define SFCFS_F_PERR 4
`define SFCFS_F_PSUSP 2
`define SFCFS_F_PROT 1
// ***************
// protocols and lanes
// ***************
`define SFCFS_P_EXT 2'h0
`define SFCFS_P_DUAL 2'h1
`define SFCFS_P_QUAD 2'h2
`define SFCFS_L1 2'h0
`define SFCFS_L2 2'h1
`define SFCFS_L4 2'h2
// ***************
// command kinds
// ***************
`define SFCFS_K_CTRL 3'h0
`define SFCFS_K_RDFLAG 3'h1
`define SFCFS_K_CLRFLAG 3'h2
`define SFCFS_K_WREN 3'h3
`define SFCFS_K_WRDI 3'h4
`define SFCFS_K_READ 3'h5
`define SFCFS_K_MODIFY 3'h6
`define SFCFS_K_REGRD 3'h7
// ***************
// link states
// ***************
`define SFCFS_S_IDLE 3'h0
`define SFCFS_S_CODE 3'h1
`define SFCFS_S_ADDR 3'h2
`define SFCFS_S_DUMMY 3'h3
`define SFCFS_S_OUT 3'h4
`define SFCFS_S_IN 3'h5
`define SFCFS_S_SKIP 3'h6
// ***************
// counts
// ***************
`define SFCFS_BYTE_BITS 4'h8
`define SFCFS_ADDR_BYTES 2'h3
`define SFCFS_DUMMY_DEF 4'h8
`define SFCFS_DUMMY_QUAD 4'ha
`define SFCFS_DUMMY_ALT 4'hf
`define SFCFS_ID_MAX 5'h14
`define SFCFS_MID_MAX 5'h03
`define SFCFS_NO_MAX 5'h00
`endif

// ### hdl/sfcfs_sync.v
`default_nettype none
module sfcfs_sync #(
    parameter W = 6
) (
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    input wire [W-1:0] d_in,
    output wire [W-1:0] q_out
);
    // ***************
    // two-stage capture per bit
    // ***************
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta;
            reg stable;
            always @(posedge clk_in) begin
                if (rst_in) begin
                    meta <= 1'b1;
                    stable <= 1'b1;
                end else if (ce_in) begin
                    meta <= d_in[i];
                    stable <= meta;
                end
            end
            assign q_out[i] = stable;
        end
    endgenerate
endmodule
`default_nettype wire

// ### hdl/sfcfs_decode.v
`default_nettype none
`include "sfcfs_regs.vh"
module sfcfs_decode (
    input wire [7:0] code_in,
    input wire [1:0] proto_in,
    output reg acc_out,
    output reg [2:0] kind_out,
    output reg addr_out,
    output reg dummy_out,
    output reg [1:0] alane_out,
    output reg [1:0] dlane_out,
    output reg [4:0] maxb_out,
    output reg erase_out,
    output reg otp_out
);
    wire ext = (proto_in == `SFCFS_P_EXT);
    wire dual = (proto_in == `SFCFS_P_DUAL);
    wire quad = (proto_in == `SFCFS_P_QUAD);
    wire [1:0] plane = quad ? `SFCFS_L4 : (dual ? `SFCFS_L2 : `SFCFS_L1);
    always @* begin
        acc_out = 1'b1;
        kind_out = `SFCFS_K_CTRL;
        addr_out = 1'b0;
        dummy_out = 1'b0;
        alane_out = plane;
        dlane_out = plane;
        maxb_out = `SFCFS_NO_MAX;
        erase_out = 1'b0;
        otp_out = 1'b0;
        case (code_in)
            8'h70: kind_out = `SFCFS_K_RDFLAG;
            8'h50: kind_out = `SFCFS_K_CLRFLAG;
            8'h06: kind_out = `SFCFS_K_WREN;
            8'h04: kind_out = `SFCFS_K_WRDI;
            8'h66, 8'h99, 8'h7a, 8'h75, 8'h35, 8'hf5:
                kind_out = `SFCFS_K_CTRL;
            8'h05, 8'hb5, 8'h85, 8'h65: kind_out = `SFCFS_K_REGRD;
            8'h9e, 8'h9f: begin
                acc_out = ext;
                kind_out = `SFCFS_K_REGRD;
                maxb_out = `SFCFS_ID_MAX;
            end
            8'haf: begin
                acc_out = !ext;
                kind_out = `SFCFS_K_REGRD;
                maxb_out = `SFCFS_MID_MAX;
            end
            8'h03, 8'he8: begin
                acc_out = ext | (code_in == 8'he8);
                kind_out = `SFCFS_K_READ;
                addr_out = 1'b1;
            end
            8'h5a, 8'h0b, 8'h4b: begin
                kind_out = `SFCFS_K_READ;
                addr_out = 1'b1;
                dummy_out = 1'b1;
            end
            8'h3b: begin
                acc_out = !quad;
                kind_out = `SFCFS_K_READ;
                addr_out = 1'b1;
                dummy_out = 1'b1;
                dlane_out = `SFCFS_L2;
            end
            8'hbb: begin
                acc_out = !quad;
                kind_out = `SFCFS_K_READ;
                addr_out = 1'b1;
                dummy_out = 1'b1;
                alane_out = `SFCFS_L2;
                dlane_out = `SFCFS_L2;
            end
            8'h6b: begin
                acc_out = !dual;
                kind_out = `SFCFS_K_READ;
                addr_out = 1'b1;
                dummy_out = 1'b1;
                dlane_out = `SFCFS_L4;
            end
            8'heb: begin
                acc_out = !dual;
                kind_out = `SFCFS_K_READ;
                addr_out = 1'b1;
                dummy_out = 1'b1;
                alane_out = `SFCFS_L4;
                dlane_out = `SFCFS_L4;
            end
            8'h01, 8'he5, 8'hb1, 8'h81, 8'h61:
                kind_out = `SFCFS_K_MODIFY;
            8'h02, 8'h42: begin
                kind_out = `SFCFS_K_MODIFY;
                addr_out = 1'b1;
                otp_out = (code_in == 8'h42);
            end
            8'ha2, 8'hd2: begin
                acc_out = !quad;
                kind_out = `SFCFS_K_MODIFY;
                addr_out = 1'b1;
                alane_out = (code_in == 8'hd2) ? `SFCFS_L2 : plane;
                dlane_out = `SFCFS_L2;
            end
            8'h32, 8'h12, 8'h38: begin
                acc_out = !dual;
                kind_out = `SFCFS_K_MODIFY;
                addr_out = 1'b1;
                alane_out = (code_in == 8'h32) ? plane : `SFCFS_L4;
                dlane_out = `SFCFS_L4;
            end
            8'h20, 8'h52, 8'hd8, 8'hc7: begin
                kind_out = `SFCFS_K_MODIFY;
                addr_out = (code_in != 8'hc7);
                erase_out = 1'b1;
            end
            default: acc_out = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ### hdl/sfcfs_top.v
`default_nettype none
`include "sfcfs_regs.vh"
module sfcfs_top (
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    input wire sclk_in,
    input wire cs_n_in,
    input wire [3:0] dq_in,
    output reg [3:0] dq_out,
    output reg [3:0] dq_oe_out,
    input wire [1:0] proto_in,
    input wire [3:0] dummy_cfg_in,
    input wire pe_busy_in,
    input wire erase_susp_in,
    input wire prog_susp_in,
    input wire erase_fail_in,
    input wire prog_fail_in,
    input wire prot_erase_in,
    input wire prot_prog_in,
    input wire otp_locked_in,
    input wire [7:0] rd_data_in,
    output reg rd_req_out,
    output reg [7:0] cmd_out,
    output reg [23:0] addr_out,
    output reg exec_out,
    output reg [7:0] wr_data_out,
    output reg wr_strobe_out,
    output reg wel_out,
    output reg [7:0] flags_out
);
    // ***************
    // link input capture
    // ***************
    wire [5:0] sync_q;
    sfcfs_sync #(.W(6)) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .d_in({sclk_in, cs_n_in, dq_in}),
        .q_out(sync_q)
    );
    wire sclk_s = sync_q[5];
    wire cs_n_s = sync_q[4];
    wire [3:0] dq_s = sync_q[3:0];
    reg sclk_d;
    reg cs_n_d;
    wire sclk_rise = sclk_s & ~sclk_d;
    wire sclk_fall = ~sclk_s & sclk_d;
    wire cs_start = ~cs_n_s & cs_n_d;
    wire cs_end = cs_n_s & ~cs_n_d;

    // ***************
    // command state
    // ***************
    reg [2:0] state;
    reg [7:0] sh;
    reg [3:0] bitcnt;
    reg [1:0] acnt;
    reg [3:0] dcnt;
    reg [2:0] kind;
    reg has_dummy;
    reg [1:0] alane;
    reg [1:0] dlane;
    reg [4:0] maxb;
    reg [4:0] bytes;
    reg is_erase;
    reg is_otp;
    reg blocked;
    reg [7:0] osh;
    reg [2:0] ocnt;
    reg err_e;
    reg err_p;
    reg err_prot;

    wire [1:0] plane = (proto_in == `SFCFS_P_QUAD) ? `SFCFS_L4 :
        ((proto_in == `SFCFS_P_DUAL) ? `SFCFS_L2 : `SFCFS_L1);
    wire [1:0] in_lane = (state == `SFCFS_S_CODE) ? plane :
        ((state == `SFCFS_S_ADDR) ? alane : dlane);
    wire [3:0] in_step = (in_lane == `SFCFS_L4) ? 4'h4 :
        ((in_lane == `SFCFS_L2) ? 4'h2 : 4'h1);
    wire [2:0] out_step = in_step[2:0];
    reg [7:0] next_sh;
    always @* begin
        case (in_lane)
            `SFCFS_L2: next_sh = {sh[5:0], dq_s[1:0]};
            `SFCFS_L4: next_sh = {sh[3:0], dq_s};
            default: next_sh = {sh[6:0], dq_s[0]};
        endcase
    end
    wire [3:0] next_bitcnt = bitcnt + in_step;
    wire byte_done = (next_bitcnt == `SFCFS_BYTE_BITS);

    wire d_acc;
    wire [2:0] d_kind;
    wire d_addr;
    wire d_dummy;
    wire [1:0] d_alane;
    wire [1:0] d_dlane;
    wire [4:0] d_maxb;
    wire d_erase;
    wire d_otp;
    sfcfs_decode u_dec (
        .code_in(next_sh),
        .proto_in(proto_in),
        .acc_out(d_acc),
        .kind_out(d_kind),
        .addr_out(d_addr),
        .dummy_out(d_dummy),
        .alane_out(d_alane),
        .dlane_out(d_dlane),
        .maxb_out(d_maxb),
        .erase_out(d_erase),
        .otp_out(d_otp)
    );

    // dummy count: 0 or all-ones keep the default
    wire dummy_dflt = (dummy_cfg_in == 4'h0) |
        (dummy_cfg_in == `SFCFS_DUMMY_ALT);
    wire [3:0] dummy_n = !dummy_dflt ? dummy_cfg_in :
        ((proto_in == `SFCFS_P_QUAD) ? `SFCFS_DUMMY_QUAD :
        `SFCFS_DUMMY_DEF);

    wire any_err = err_e | err_p | err_prot;
    wire code_done = (state == `SFCFS_S_CODE) & sclk_rise & byte_done;
    wire clr_cmd = code_done & d_acc & (d_kind == `SFCFS_K_CLRFLAG);
    wire err_cmd = code_done & d_acc & (d_kind == `SFCFS_K_MODIFY) &
        any_err;
    wire otp_hit = cs_end & (kind == `SFCFS_K_MODIFY) & is_otp &
        otp_locked_in & wel_out & !blocked;

    // ***************
    // flag register
    // ***************
    always @(posedge clk_in) begin
        if (rst_in) begin
            err_e <= 1'b0;
            err_p <= 1'b0;
            err_prot <= 1'b0;
            flags_out <= 8'h80;
        end else if (ce_in) begin
            // set terms win over the clear command
            err_e <= (err_e & ~clr_cmd) | erase_fail_in | prot_erase_in |
                (err_cmd & d_erase);
            err_p <= (err_p & ~clr_cmd) | prog_fail_in | prot_prog_in |
                (err_cmd & ~d_erase) | otp_hit;
            err_prot <= (err_prot & ~clr_cmd) | prot_erase_in |
                prot_prog_in | err_cmd | otp_hit;
            flags_out[`SFCFS_F_READY] <= ~pe_busy_in;
            flags_out[`SFCFS_F_ESUSP] <= erase_susp_in;
            flags_out[`SFCFS_F_EERR] <= err_e;
            flags_out[`SFCFS_F_PERR] <= err_p;
            flags_out[`SFCFS_F_PSUSP] <= prog_susp_in;
            flags_out[`SFCFS_F_PROT] <= err_prot;
            flags_out[3] <= 1'b0;
            flags_out[0] <= 1'b0;
        end
    end

    // ***************
    // link command engine
    // ***************
    always @(posedge clk_in) begin
        if (rst_in) begin
            sclk_d <= 1'b1;
            cs_n_d <= 1'b1;
            state <= `SFCFS_S_IDLE;
            sh <= 8'h00;
            bitcnt <= 4'h0;
            acnt <= 2'h0;
            dcnt <= 4'h0;
            kind <= `SFCFS_K_CTRL;
            has_dummy <= 1'b0;
            alane <= `SFCFS_L1;
            dlane <= `SFCFS_L1;
            maxb <= `SFCFS_NO_MAX;
            bytes <= 5'h00;
            is_erase <= 1'b0;
            is_otp <= 1'b0;
            blocked <= 1'b0;
            osh <= 8'h00;
            ocnt <= 3'h0;
            dq_out <= 4'h0;
            dq_oe_out <= 4'h0;
            rd_req_out <= 1'b0;
            cmd_out <= 8'h00;
            addr_out <= 24'h000000;
            exec_out <= 1'b0;
            wr_data_out <= 8'h00;
            wr_strobe_out <= 1'b0;
            wel_out <= 1'b0;
        end else if (ce_in) begin
            sclk_d <= sclk_s;
            cs_n_d <= cs_n_s;
            rd_req_out <= 1'b0;
            exec_out <= 1'b0;
            wr_strobe_out <= 1'b0;
            if (cs_end) begin
                dq_oe_out <= 4'h0;
                state <= `SFCFS_S_IDLE;
                if (state != `SFCFS_S_IDLE && state != `SFCFS_S_CODE &&
                        kind == `SFCFS_K_MODIFY) begin
                    // only a write-enabled, error-free modify runs
                    if (wel_out && !blocked && !otp_hit) begin
                        exec_out <= 1'b1;
                        wel_out <= 1'b0;
                    end
                end else if (state == `SFCFS_S_SKIP &&
                        kind == `SFCFS_K_CTRL && !blocked) begin
                    exec_out <= 1'b1;
                end
            end else if (cs_start) begin
                state <= `SFCFS_S_CODE;
                bitcnt <= 4'h0;
                acnt <= 2'h0;
                bytes <= 5'h00;
                ocnt <= 3'h0;
            end else if (sclk_rise) begin
                sh <= next_sh;
                bitcnt <= byte_done ? 4'h0 : next_bitcnt;
                case (state)
                    `SFCFS_S_CODE: begin
                        if (byte_done) begin
                            kind <= d_kind;
                            has_dummy <= d_dummy;
                            alane <= d_alane;
                            dlane <= d_dlane;
                            maxb <= d_maxb;
                            is_erase <= d_erase;
                            is_otp <= d_otp;
                            blocked <= !d_acc | any_err;
                            if (!d_acc) begin
                                state <= `SFCFS_S_SKIP;
                            end else begin
                                cmd_out <= next_sh;
                                if (d_kind == `SFCFS_K_WREN)
                                    wel_out <= 1'b1;
                                if (d_kind == `SFCFS_K_WRDI)
                                    wel_out <= 1'b0;
                                case (d_kind)
                                    `SFCFS_K_RDFLAG,
                                    `SFCFS_K_REGRD:
                                        state <= `SFCFS_S_OUT;
                                    `SFCFS_K_READ:
                                        state <= `SFCFS_S_ADDR;
                                    `SFCFS_K_MODIFY:
                                        state <= d_addr ? `SFCFS_S_ADDR :
                                            `SFCFS_S_IN;
                                    default:
                                        state <= `SFCFS_S_SKIP;
                                endcase
                            end
                        end
                    end
                    `SFCFS_S_ADDR: begin
                        if (byte_done) begin
                            addr_out <= {addr_out[15:0], next_sh};
                            acnt <= acnt + 2'h1;
                            if (acnt == `SFCFS_ADDR_BYTES - 2'h1) begin
                                dcnt <= 4'h0;
                                if (kind == `SFCFS_K_MODIFY)
                                    state <= `SFCFS_S_IN;
                                else if (has_dummy)
                                    state <= `SFCFS_S_DUMMY;
                                else
                                    state <= `SFCFS_S_OUT;
                            end
                        end
                    end
                    `SFCFS_S_DUMMY: begin
                        bitcnt <= 4'h0;
                        dcnt <= dcnt + 4'h1;
                        if (dcnt + 4'h1 == dummy_n)
                            state <= `SFCFS_S_OUT;
                    end
                    `SFCFS_S_IN: begin
                        if (byte_done && !blocked) begin
                            wr_data_out <= next_sh;
                            wr_strobe_out <= 1'b1;
                        end
                    end
                    default: bitcnt <= 4'h0;
                endcase
            end else if (sclk_fall && state == `SFCFS_S_OUT) begin
                if (ocnt == 3'h0) begin
                    if (maxb != `SFCFS_NO_MAX && bytes == maxb) begin
                        dq_oe_out <= 4'h0;
                        state <= `SFCFS_S_SKIP;
                    end else begin
                        bytes <= bytes + 5'h01;
                        // flags stream repeatedly, others from the array
                        if (kind == `SFCFS_K_RDFLAG) begin
                            osh <= flags_out << out_step;
                            dq_out <= out_bits(flags_out);
                        end else begin
                            rd_req_out <= 1'b1;
                            osh <= rd_data_in << out_step;
                            dq_out <= out_bits(rd_data_in);
                        end
                        dq_oe_out <= out_en(dlane);
                    end
                end else begin
                    osh <= osh << out_step;
                    dq_out <= out_bits(osh);
                end
                ocnt <= ocnt + out_step;
            end
        end
    end

    // ***************
    // output lane helpers
    // ***************
    function [3:0] out_bits;
        input [7:0] b;
        begin
            case (dlane)
                `SFCFS_L2: out_bits = {2'h0, b[7:6]};
                `SFCFS_L4: out_bits = b[7:4];
                default: out_bits = {2'h0, b[7], 1'b0};
            endcase
        end
    endfunction

    function [3:0] out_en;
        input [1:0] l;
        begin
            case (l)
                `SFCFS_L2: out_en = 4'h3;
                `SFCFS_L4: out_en = 4'hf;
                default: out_en = 4'h2;
            endcase
        end
    endfunction
endmodule
`default_nettype wire

// ### tb/sfcfs_chk.sv
`default_nettype none
module sfcfs_chk (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic pe_busy_in,
    input wire logic erase_susp_in,
    input wire logic prog_susp_in,
    input wire logic erase_fail_in,
    input wire logic prog_fail_in,
    input wire logic prot_erase_in,
    input wire logic prot_prog_in,
    input wire logic [7:0] cmd_out,
    input wire logic exec_out,
    input wire logic wel_out,
    input wire logic [7:0] flags_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    sequence s_run;
        !$past(rst_in);
    endsequence
    sequence s_erase_err;
        erase_fail_in || prot_erase_in;
    endsequence
    sequence s_prog_err;
        prog_fail_in || prot_prog_in;
    endsequence
    sequence s_write_exec;
        exec_out && cmd_out == 8'h02;
    endsequence
    AST_READY: assert property (
        s_run |-> flags_out[7] == !$past(pe_busy_in))
        else $error("ready flag does not follow busy input");
    AST_ESUSP: assert property (
        s_run |-> flags_out[6] == $past(erase_susp_in))
        else $error("erase suspend flag wrong");
    AST_PSUSP: assert property (
        s_run |-> flags_out[2] == $past(prog_susp_in))
        else $error("program suspend flag wrong");
    AST_EERR: assert property (
        s_erase_err |=> ##1 flags_out[5])
        else $error("erase error flag not set");
    AST_PERR: assert property (
        s_prog_err |=> ##1 flags_out[4])
        else $error("program error flag not set");
    AST_PROT: assert property (
        prot_erase_in || prot_prog_in |=> ##1 flags_out[1])
        else $error("protection flag not set");
    AST_CLR: assert property (
        s_run ##0 (|($past(flags_out) & ~flags_out & 8'h32))
        |-> cmd_out == 8'h50)
        else $error("error flag dropped without clear command");
    AST_WEL: assert property (
        s_write_exec |-> $past(wel_out) || wel_out)
        else $error("program executed without write enable");
    AST_ERRBLK: assert property (
        s_write_exec |-> $past(flags_out[5:4]) == 2'h0)
        else $error("program executed while error pending");
endmodule
bind sfcfs_top sfcfs_chk sfcfs_chk_inst (
    .clk_in, .rst_in, .pe_busy_in, .erase_susp_in, .prog_susp_in,
    .erase_fail_in, .prog_fail_in, .prot_erase_in, .prot_prog_in,
    .cmd_out, .exec_out, .wel_out, .flags_out
);
`default_nettype wire

// ### tb/sfcfs_host.sv
`default_nettype none
module sfcfs_host (
    output logic sclk_out,
    output logic cs_n_out,
    output logic [3:0] dq_out,
    input wire logic [3:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        dq_out = 4'h0;
    end
    // one byte, msb first, l lanes per rise; sample late in high phase
    task automatic shift(input [7:0] b, input int l, inout logic [7:0] r);
        logic [3:0] m;
        m = (l == 1) ? 4'h1 : (l == 2) ? 4'h3 : 4'hf;
        for (int i = 8 - l; i >= 0; i -= l) begin
            dq_out = 4'(b >> i) & m;
            #400 sclk_out = 1'b1;
            #390 r = (r << l) | 8'((l == 1) ? dq_in[1] : dq_in & m);
            #10 sclk_out = 1'b0;
        end
    endtask
    task automatic xfer(input [7:0] code, input int l, input int na,
                        input int nb, input [7:0] wb,
                        output logic [7:0] r);
        r = 8'h00;
        cs_n_out = 1'b0;
        #400;
        shift(code, l, r);
        repeat (na) shift(wb, l, r);
        repeat (nb) shift(wb, l, r);
        #400 cs_n_out = 1'b1;
        // released lines must not keep the last value
        dq_out = ~dq_out;
        #2000;
    endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [1:0] proto = 2'h0;
    logic [2:0] lvl = 3'h0;
    logic [3:0] ev = 4'h0;
    logic otp_lock = 1'b0;
    logic [7:0] rd_data = 8'h00;
    logic sclk, cs_n, exec, wel;
    logic [3:0] host_dq, dev_dq, dev_oe;
    logic [7:0] cmd, wr_data, flags;
    logic [23:0] addr;
    wire [3:0] dq_line = (dev_oe & dev_dq) | (~dev_oe & host_dq);
    int n_errors = 0;
    int comparisons = 0;
    int n_exec = 0;
    logic [7:0] exp_q[$];
    logic [7:0] got_q[$];
    string name_q[$];
    logic [15:0] tbl[24] = '{16'h09f1, 16'h09e1, 16'h0af0, 16'h05a1,
        16'h03b1, 16'h0bb1, 16'h06b1, 16'h0eb1, 16'h19f0, 16'h1af1,
        16'h15a1, 16'h13b1, 16'h1bb1, 16'h10b1, 16'h16b0, 16'h1eb0,
        16'h1030, 16'h29e0, 16'h2af1, 16'h25a1, 16'h23b0, 16'h2bb0,
        16'h26b1, 16'h20b1};
    initial forever #50 clk_in = ~clk_in;
    always @(posedge clk_in) if (exec === 1'b1) n_exec++;
    sfcfs_host sfcfs_host_inst (.sclk_out(sclk), .cs_n_out(cs_n),
        .dq_out(host_dq), .dq_in(dq_line));
    sfcfs_top sfcfs_top_inst (.clk_in(clk_in), .rst_in(rst_in),
        .ce_in(1'b1), .sclk_in(sclk), .cs_n_in(cs_n), .dq_in(dq_line),
        .dq_out(dev_dq), .dq_oe_out(dev_oe), .proto_in(proto),
        .dummy_cfg_in(4'h0), .pe_busy_in(lvl[2]), .erase_susp_in(lvl[1]),
        .prog_susp_in(lvl[0]), .erase_fail_in(ev[3]),
        .prog_fail_in(ev[2]), .prot_erase_in(ev[1]), .prot_prog_in(ev[0]),
        .otp_locked_in(otp_lock), .rd_data_in(rd_data), .rd_req_out(),
        .cmd_out(cmd), .addr_out(addr), .exec_out(exec),
        .wr_data_out(wr_data), .wr_strobe_out(), .wel_out(wel),
        .flags_out(flags));
    // ***************
    // checking
    // ***************
    task automatic check(string what, logic [7:0] got, logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic put(string what, logic [7:0] exp, logic [7:0] got);
        name_q.push_back(what);
        exp_q.push_back(exp);
        got_q.push_back(got);
    endtask
    initial forever begin
        @(negedge clk_in);
        while (got_q.size() > 0)
            check(name_q.pop_front(), got_q.pop_front(), exp_q.pop_front());
    end
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #8ms;
        n_errors++;
        final_report();
    end
    // ***************
    // stimulus
    // ***************
    function automatic int lanes(logic [1:0] p);
        return (p == 2'h0) ? 1 : (p == 2'h1) ? 2 : 4;
    endfunction
    task automatic cmd_frame(logic [7:0] c, int na, int nb, logic [7:0] w);
        logic [7:0] r;
        @(negedge clk_in);
        sfcfs_host_inst.xfer(c, lanes(proto), na, nb, w, r);
    endtask
    task automatic rd_flags(logic [7:0] exp);
        logic [7:0] r;
        @(negedge clk_in);
        sfcfs_host_inst.xfer(8'h70, lanes(proto), 0, 1, 8'h00, r);
        put("flags", exp, r);
    endtask
    task automatic pulse(logic [3:0] m);
        @(posedge clk_in);
        ev <= m;
        @(posedge clk_in);
        ev <= 4'h0;
    endtask
    task automatic set_in(logic [1:0] p, logic [2:0] v, logic o);
        @(posedge clk_in);
        proto <= p;
        lvl <= v;
        otp_lock <= o;
        @(posedge clk_in);
    endtask
    initial begin
        logic [2:0] v;
        logic [7:0] w;
        int e0;
        void'($urandom(33350));
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        rd_data <= 8'($urandom);
        repeat (4) @(posedge clk_in);
        rd_flags(8'h80);
        cmd_frame(8'h06, 0, 0, 8'h00);
        put("wel", 8'h01, {7'h0, wel});
        rd_flags(8'h80);
        $display("test reset_and_write_enable done");
        for (int p = 0; p < 3; p++) begin
            v = 3'($urandom) | 3'(1 << p);
            set_in(2'(p), v, 1'b0);
            rd_flags({~v[2], v[1], 3'h0, v[0], 2'h0});
        end
        set_in(2'h0, 3'h0, 1'b0);
        rd_flags(8'h80);
        $display("test status_flags done");
        pulse(4'h8);
        rd_flags(8'ha0);
        pulse(4'h4);
        pulse(4'h2);
        rd_flags(8'hb2);
        rd_flags(8'hb2);
        cmd_frame(8'h50, 0, 0, 8'h00);
        rd_flags(8'h80);
        pulse(4'h1);
        rd_flags(8'h92);
        cmd_frame(8'h50, 0, 0, 8'h00);
        pulse(4'h8);
        e0 = n_exec;
        cmd_frame(8'h06, 0, 0, 8'h00);
        cmd_frame(8'h02, 3, 1, 8'h3c);
        put("exec", 8'h00, 8'(n_exec - e0));
        rd_flags(8'hb2);
        cmd_frame(8'h50, 0, 0, 8'h00);
        set_in(2'h0, 3'h0, 1'b1);
        cmd_frame(8'h06, 0, 0, 8'h00);
        cmd_frame(8'h42, 3, 1, 8'h5a);
        rd_flags(8'h92);
        cmd_frame(8'h50, 0, 0, 8'h00);
        set_in(2'h0, 3'h0, 1'b0);
        cmd_frame(8'h04, 0, 0, 8'h00);
        e0 = n_exec;
        cmd_frame(8'h02, 3, 1, 8'h11);
        put("exec", 8'h00, 8'(n_exec - e0));
        w = 8'($urandom);
        cmd_frame(8'h06, 0, 0, 8'h00);
        cmd_frame(8'h02, 3, 1, w);
        put("exec", 8'h01, 8'(n_exec - e0));
        put("wr_data", w, wr_data);
        put("wel", 8'h00, {7'h0, wel});
        sfcfs_host_inst.xfer(8'h5a, 1, 4, 1, 8'h3c, w);
        put("sfdp", rd_data, w);
        put("addr", 8'h3c, addr[23:16]);
        $display("test error_flags done");
        foreach (tbl[i]) begin
            set_in(2'(tbl[i][13:12]), 3'h0, 1'b0);
            cmd_frame(8'h70, 0, 1, 8'h00);
            cmd_frame(tbl[i][11:4], 0, 0, 8'h00);
            w = tbl[i][0] ? tbl[i][11:4] : 8'h70;
            put("cmd", w, cmd);
        end
        sfcfs_host_inst.xfer(8'h5a, 4, 8, 1, 8'h00, w);
        put("sfdp", rd_data, w);
        rd_flags(8'h80);
        $display("test code_acceptance done");
        #300;
        final_report();
    end
endmodule
`default_nettype wire
